/* design/tbrt_top.sv */
// three-lane registered bus transceiver with avalon control and status
`default_nettype none
module tbrt_top
  import tbrt_pkg::*;
#(
  parameter logic [1:0] COMBINE_MODE = TBRT_MODE_OR,
  parameter logic LOAD_ACTIVE_HIGH = 1'b1
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clock_a,
  input wire logic clock_b,
  input wire tbrt_pkg::tbrt_data_t data_in,
  input wire logic transmit_load_enable,
  input wire logic [1:0] bus_drive_enable,
  input wire logic receive_gate_enable,
  input wire logic [TBRT_LANES-1:0] shared_bus_lines_in,
  output logic [TBRT_LANES-1:0] shared_bus_lines_out,
  output logic [TBRT_LANES-1:0] shared_bus_lines_oe_n,
  output logic [TBRT_LANES-1:0] receive_outputs,
  input wire tbrt_pkg::tbrt_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import tbrt_pkg::*;

  function automatic logic [TBRT_LANES-1:0] combine_ab(
    input logic [TBRT_LANES-1:0] a,
    input logic [TBRT_LANES-1:0] b,
    input logic [1:0] mode
  );
    case (mode)
      TBRT_MODE_OR: combine_ab = a | b;
      TBRT_MODE_AND: combine_ab = a & b;
      TBRT_MODE_A: combine_ab = a;
      TBRT_MODE_B: combine_ab = b;
      default: combine_ab = a | b;
    endcase
  endfunction

  // rising edge against the previous enabled sample of the same pin
  function automatic logic rose_since(
    input logic now_level,
    input logic last_level
  );
    rose_since = now_level & ~last_level;
  endfunction

  function automatic logic addr_hit(
    input logic [TBRT_ADDR_W-1:0] addr,
    input logic [TBRT_ADDR_W-1:0] target
  );
    addr_hit = (addr == target);
  endfunction

  function automatic logic [31:0] ctrl_word(
    input logic [1:0] mode,
    input logic pol
  );
    ctrl_word = TBRT_ZERO_WORD;
    ctrl_word[TBRT_CTRL_MODE_LSB +: 2] = mode;
    ctrl_word[TBRT_CTRL_POL_BIT] = pol;
  endfunction

  // bus is the resolved wire, so software sees the other drivers too
  function automatic logic [31:0] status_word(
    input logic [TBRT_LANES-1:0] tx,
    input logic [TBRT_LANES-1:0] rx,
    input logic en,
    input logic [TBRT_LANES-1:0] bus
  );
    status_word = TBRT_ZERO_WORD;
    status_word[TBRT_STAT_TX_LSB +: TBRT_LANES] = tx;
    status_word[TBRT_STAT_RX_LSB +: TBRT_LANES] = rx;
    status_word[TBRT_STAT_EN_BIT] = en;
    status_word[TBRT_STAT_BUS_LSB +: TBRT_LANES] = bus;
  endfunction

  logic clock_a_reg;
  logic clock_b_reg;
  logic clk_edge;
  logic [1:0] mode_reg;
  logic pol_reg;
  logic bus_en_reg;
  logic bus_en_next;
  logic load;
  logic [TBRT_LANES-1:0] din;
  logic [TBRT_LANES-1:0] tx_q;
  logic answering;
  logic ctrl_wr;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic req;

  typedef enum logic [1:0] {
    TBRT_AVS_IDLE = 2'b01,
    TBRT_AVS_ANSWER = 2'b10
  } tbrt_avs_state_t;

  tbrt_avs_state_t avs_state_reg;
  tbrt_avs_state_t avs_state_next;

  // pins are synchronous, so edge detect by a single previous sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_a_reg <= 1'b0;
      clock_b_reg <= 1'b0;
    end else if (ce) begin
      clock_a_reg <= clock_a;
      clock_b_reg <= clock_b;
    end
  end

  // coincident rises give one edge, not two
  assign clk_edge = rose_since(clock_a, clock_a_reg) | rose_since(clock_b, clock_b_reg);

  assign load = (transmit_load_enable == pol_reg);
  assign din = combine_ab(data_in.a, data_in.b, mode_reg);

  // either enable high keeps the lanes driving
  assign bus_en_next = |bus_drive_enable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_en_reg <= TBRT_EN_RST;
    end else if (ce && clk_edge) begin
      bus_en_reg <= bus_en_next;
    end
  end

  genvar i;
  generate
    for (i = 0; i < TBRT_LANES; i++) begin : g_lane
      tbrt_lane u_lane (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clk_edge(clk_edge),
        .load(load),
        .din(din[i]),
        .bus_in(shared_bus_lines_in[i]),
        .rx_gate(receive_gate_enable),
        .tx_q(tx_q[i]),
        .rx_q(receive_outputs[i])
      );
    end
  endgenerate

  // open-emitter style: only a high is driven, a low releases the line
  assign shared_bus_lines_out = {TBRT_LANES{1'b1}};
  assign shared_bus_lines_oe_n = ~(tx_q & {TBRT_LANES{bus_en_reg}});

  // avalon slave: every access answers on its second cycle
  assign req = avs_req.read | avs_req.write;
  assign answering = (avs_state_reg == TBRT_AVS_ANSWER);
  assign avs_waitrequest = req & ~answering;

  // the answer state always falls back to idle, so back-to-back accesses take two cycles each
  always_comb begin
    avs_state_next = avs_state_reg;
    case (avs_state_reg)
      TBRT_AVS_IDLE: begin
        if (req) begin
          avs_state_next = TBRT_AVS_ANSWER;
        end
      end
      TBRT_AVS_ANSWER: begin
        avs_state_next = TBRT_AVS_IDLE;
      end
      default: begin
        avs_state_next = TBRT_AVS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_state_reg <= TBRT_AVS_IDLE;
    end else if (ce) begin
      avs_state_reg <= avs_state_next;
    end
  end

  // a write lands only on the answering cycle; byte lane 0 guards the control bits
  assign ctrl_wr = avs_req.write & answering & addr_hit(avs_req.address, TBRT_CTRL_ADDR) & avs_req.byteenable[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= COMBINE_MODE;
      pol_reg <= LOAD_ACTIVE_HIGH;
    end else if (ce && ctrl_wr) begin
      mode_reg <= avs_req.writedata[TBRT_CTRL_MODE_LSB +: 2];
      pol_reg <= avs_req.writedata[TBRT_CTRL_POL_BIT];
    end
  end

  // read data is taken on the first cycle, so it shows state as it stood when the request arrived
  always_comb begin
    rdata_next = TBRT_ZERO_WORD;
    if (addr_hit(avs_req.address, TBRT_CTRL_ADDR)) begin
      rdata_next = ctrl_word(mode_reg, pol_reg);
    end else if (addr_hit(avs_req.address, TBRT_STAT_ADDR)) begin
      rdata_next = status_word(tx_q, receive_outputs, bus_en_reg, shared_bus_lines_in);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= TBRT_ZERO_WORD;
    end else if (ce && avs_req.read && !answering) begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;
endmodule // tbrt_top
`default_nettype wire

/* design/tbrt_pkg.sv */
// constants and carrier types for the three-lane registered bus transceiver
`default_nettype none
package tbrt_pkg;
  localparam int TBRT_LANES = 3;
  localparam int TBRT_ADDR_W = 4;
  // register byte addresses
  localparam logic [3:0] TBRT_CTRL_ADDR = 4'h0;
  localparam logic [3:0] TBRT_STAT_ADDR = 4'h4;
  // control field positions
  localparam int TBRT_CTRL_MODE_LSB = 0;
  localparam int TBRT_CTRL_POL_BIT = 2;
  // status field positions
  localparam int TBRT_STAT_TX_LSB = 0;
  localparam int TBRT_STAT_RX_LSB = 4;
  localparam int TBRT_STAT_EN_BIT = 8;
  localparam int TBRT_STAT_BUS_LSB = 12;
  // a/b combine modes
  localparam logic [1:0] TBRT_MODE_OR = 2'h0;
  localparam logic [1:0] TBRT_MODE_AND = 2'h1;
  localparam logic [1:0] TBRT_MODE_A = 2'h2;
  localparam logic [1:0] TBRT_MODE_B = 2'h3;
  // reset values
  localparam logic [2:0] TBRT_LANE_RST = 3'h0;
  localparam logic TBRT_EN_RST = 1'b0;
  localparam logic [31:0] TBRT_ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [TBRT_LANES-1:0] a;
    logic [TBRT_LANES-1:0] b;
  } tbrt_data_t;

  typedef struct packed {
    logic [TBRT_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tbrt_avs_req_t;
endpackage
`default_nettype wire

/* design/tbrt_lane.sv */
// one transceiver lane: transmit register and receive register
`default_nettype none
module tbrt_lane
  import tbrt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clk_edge,
  input wire logic load,
  input wire logic din,
  input wire logic bus_in,
  input wire logic rx_gate,
  output logic tx_q,
  output logic rx_q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= TBRT_LANE_RST[0];
    end else if (ce && clk_edge && load) begin
      tx_q <= din;
    end
  end

  // gate low holds the captured value rather than forcing zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= TBRT_LANE_RST[0];
    end else if (ce && clk_edge && rx_gate) begin
      rx_q <= bus_in;
    end
  end
endmodule // tbrt_lane
`default_nettype wire

/* sim/tbrt_top_sva.sv */
// assertions on the transceiver top ports
`default_nettype none
module tbrt_top_sva
  import tbrt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clock_a,
  input wire logic clock_b,
  input wire tbrt_pkg::tbrt_data_t data_in,
  input wire logic transmit_load_enable,
  input wire logic [1:0] bus_drive_enable,
  input wire logic receive_gate_enable,
  input wire logic [TBRT_LANES-1:0] shared_bus_lines_in,
  input wire logic [TBRT_LANES-1:0] shared_bus_lines_out,
  input wire logic [TBRT_LANES-1:0] shared_bus_lines_oe_n,
  input wire logic [TBRT_LANES-1:0] receive_outputs,
  input wire tbrt_pkg::tbrt_avs_req_t avs_req,
  input wire logic avs_waitrequest
);
  logic pa_reg;
  logic pb_reg;
  logic [2:0] bus_reg;
  logic load_pol_reg;
  wire logic act = ce && ((clock_a && !pa_reg) || (clock_b && !pb_reg));
  wire logic b_only = ce && clock_b && !pb_reg && !(clock_a && !pa_reg);
  wire logic ctrl_seen = ce && avs_req.write && !avs_waitrequest
    && avs_req.address == TBRT_CTRL_ADDR && avs_req.byteenable[0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_reg <= 1'h0;
      pb_reg <= 1'h0;
    end else if (ce) begin
      pa_reg <= clock_a;
      pb_reg <= clock_b;
    end
  end
  always_ff @(posedge clk) begin
    bus_reg <= shared_bus_lines_in;
  end
  // software may flip the load polarity, so the load check follows the control writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pol_reg <= 1'h1;
    end else if (ctrl_seen) begin
      load_pol_reg <= avs_req.writedata[TBRT_CTRL_POL_BIT];
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a==b makes the check hold whatever combine mode software picks
  a_tx_load: assert property (act && transmit_load_enable == load_pol_reg && |bus_drive_enable
    && data_in.a == data_in.b |=> shared_bus_lines_oe_n == ~$past(data_in.a)) else $error("transmit load wrong");
  a_bus_cutoff: assert property (act && bus_drive_enable == 2'h0 |=> shared_bus_lines_oe_n == 3'h7)
    else $error("bus not cut off");
  a_rx_capture: assert property (act && receive_gate_enable |=> receive_outputs == bus_reg)
    else $error("receive capture wrong");
  a_rx_hold: assert property (act && !receive_gate_enable |=> $stable(receive_outputs)) else $error("receive moved");
  a_idle_stable: assert property (!act |=> $stable(shared_bus_lines_oe_n) && $stable(receive_outputs))
    else $error("change without edge");
  a_clock_b: assert property (b_only && receive_gate_enable |=> receive_outputs == bus_reg)
    else $error("clock_b edge ignored");
  a_out_high: assert property (shared_bus_lines_out == 3'h7) else $error("bus drive level not high");
  a_wait_one: assert property (ce && (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest too long");
  c_clock_b: cover property (b_only);
  c_cutoff: cover property (act && bus_drive_enable == 2'h0);
  c_access: cover property (avs_waitrequest ##1 !avs_waitrequest);
endmodule // tbrt_top_sva
bind tbrt_top tbrt_top_sva i_sva (.*);
`default_nettype wire

/* sim/tbrt_bus_model.sv */
// wired-or backplane with one more transceiver that drives highs
`default_nettype none
module tbrt_bus_model
  import tbrt_pkg::*;
(
  input wire logic [TBRT_LANES-1:0] dut_out,
  input wire logic [TBRT_LANES-1:0] dut_oe_n,
  input wire logic [TBRT_LANES-1:0] other_hi,
  output logic [TBRT_LANES-1:0] bus
);
  // released lines fall to the pulldown level, only driven highs show
  assign bus = (dut_out & ~dut_oe_n) | other_hi;
endmodule // tbrt_bus_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the three-lane transceiver
`default_nettype none
`define CHK(x, y) begin check_count++; if ((x) !== (y)) begin n_errors++; $display("CHECK FAILED %0t mismatch", $time); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tbrt_pkg::*;
  typedef struct packed {
    logic [2:0] a, b;
    logic ld;
    logic [1:0] be;
    logic g;
    logic [2:0] oth;
    logic [1:0] ck;
    logic [2:0] oe, rx;
  } tbrt_row_t;
  logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1, ca = 1'h0, cb = 1'h0, ld = 1'h0, g = 1'h0, wq;
  logic [1:0] be = 2'h0;
  logic [2:0] oth = 3'h0, bus, bout, boe, rxo;
  logic [31:0] rdata, rd;
  tbrt_data_t din = '0;
  tbrt_avs_req_t req = '0;
  int n_errors = 0, check_count = 0, cyc = 0;
  // each row leans on the lane state left by the row before
  tbrt_row_t rows[6] = '{'{3'h5, 3'h2, 1'h1, 2'h1, 1'h1, 3'h0, 2'h1, 3'h0, 3'h0},
    '{3'h0, 3'h0, 1'h0, 2'h2, 1'h1, 3'h0, 2'h2, 3'h0, 3'h7}, '{3'h1, 3'h0, 1'h1, 2'h0, 1'h1, 3'h2, 2'h1, 3'h7, 3'h7},
    '{3'h4, 3'h0, 1'h1, 2'h3, 1'h0, 3'h2, 2'h1, 3'h3, 3'h7}, '{3'h0, 3'h0, 1'h1, 2'h1, 1'h1, 3'h1, 2'h2, 3'h7, 3'h5},
    '{3'h2, 3'h1, 1'h1, 2'h1, 1'h1, 3'h0, 2'h3, 3'h4, 3'h0}};
  tbrt_top i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .clock_a(ca), .clock_b(cb), .data_in(din),
    .transmit_load_enable(ld), .bus_drive_enable(be), .receive_gate_enable(g), .shared_bus_lines_in(bus),
    .shared_bus_lines_out(bout), .shared_bus_lines_oe_n(boe), .receive_outputs(rxo), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(wq));
  tbrt_bus_model i_bus (.dut_out(bout), .dut_oe_n(boe), .other_hi(oth), .bus(bus));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic wrap_up;
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic step(input tbrt_row_t r);
    @(posedge clk);
    din <= '{r.a, r.b};
    ld <= r.ld;
    be <= r.be;
    g <= r.g;
    oth <= r.oth;
    ca <= r.ck[0];
    cb <= r.ck[1];
    @(posedge clk);
    ca <= 1'h0;
    cb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic av(input logic rn, input logic [3:0] ad, input logic [31:0] wd, input logic [3:0] en);
    @(posedge clk);
    req <= '{ad, rn, !rn, wd, en};
    do @(posedge clk); while (wq !== 1'h0);
    rd = rdata;
    req <= '0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    `CHK({boe, rxo, bout}, 9'h1C7)
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      step(rows[i]);
      `CHK({boe, rxo}, {rows[i].oe, rows[i].rx})
    end
    av(1'h1, TBRT_STAT_ADDR, 32'h0, 4'hF);
    `CHK(rd, 32'h0000_3103)
    av(1'h1, 4'h8, 32'h0, 4'hF);
    `CHK(rd, TBRT_ZERO_WORD)
    ce <= 1'h0;
    step(tbrt_row_t'{3'h0, 3'h0, 1'h1, 2'h0, 1'h1, 3'h7, 2'h1, 3'h0, 3'h0});
    `CHK({boe, rxo}, 6'h20)
    ce <= 1'h1;
    // and mode with polarity kept high; the second write has no byte lane and must not land
    av(1'h0, TBRT_CTRL_ADDR, 32'h5, 4'h1);
    av(1'h0, TBRT_CTRL_ADDR, 32'h3, 4'h0);
    step(tbrt_row_t'{3'h6, 3'h3, 1'h1, 2'h1, 1'h0, 3'h0, 2'h1, 3'h0, 3'h0});
    `CHK(boe, 3'h5)
    av(1'h0, TBRT_CTRL_ADDR, 32'h3, 4'h1);
    av(1'h1, TBRT_CTRL_ADDR, 32'h0, 4'hF);
    `CHK(rd, 32'h0000_0003)
    step(tbrt_row_t'{3'h1, 3'h6, 1'h0, 2'h1, 1'h0, 3'h0, 2'h2, 3'h0, 3'h0});
    `CHK(boe, 3'h1)
    av(1'h0, TBRT_CTRL_ADDR, 32'h6, 4'h1);
    step(tbrt_row_t'{3'h4, 3'h3, 1'h1, 2'h1, 1'h0, 3'h0, 2'h1, 3'h0, 3'h0});
    `CHK(boe, 3'h3)
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    `CHK({boe, rxo}, 6'h38)
    rst_n <= 1'h1;
    step(tbrt_row_t'{3'h6, 3'h3, 1'h1, 2'h1, 1'h1, 3'h5, 2'h1, 3'h0, 3'h0});
    `CHK({boe, rxo}, 6'h05)
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
